/* File: design/standby_status_bank.v */
// read-only standby status word bank with apb slave, interface poller and event interrupt
//
// Implementation choice: register access over APB.
`include "standby_status_regs.vh"

module standby_status_bank #(
    parameter ADDR_W = 12
) (
    input wire i_clk_sys,
    input wire i_arst_n,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [ADDR_W-1:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // file problem flags and redundancy levels, asynchronous pins
    input wire [3:0] i_file_problem,
    input wire i_standalone,
    input wire i_not_connected,
    // fieldbus interface memory read port, one wait state ram
    output reg [11:0] o_if_addr,
    output reg o_if_rd,
    input wire [7:0] i_if_rdata,
    // interface control, same clock
    input wire i_if_reset,
    input wire i_outputs_refreshed,
    // datagram redundancy server, same clock
    input wire i_dgram_valid,
    input wire [15:0] i_dgram_length,
    input wire [15:0] i_dgram_status,
    // indicators
    output reg o_cfg_fault_led,
    output reg o_irq
);

    // ****************************************************************
    // functions
    // ****************************************************************

    // word index of an apb byte address; misaligned gives no match
    function [7:0] word_index;
        input [ADDR_W-1:0] addr;
        begin
            if (addr[1:0] != 2'b00) begin
                word_index = 8'hff;
            end else begin
                word_index = addr[9:2];
            end
        end
    endfunction

    // strip the unused positions of a status byte
    function [7:0] clean_status;
        input [7:0] raw;
        begin
            clean_status = raw & `STATUS_UNUSED_MASK;
        end
    endfunction

    // poll slot to interface location
    function [11:0] slot_addr;
        input [1:0] slot;
        begin
            case (slot)
                2'd0: slot_addr = `IF_ADDR_REMOTE_STATUS;
                2'd1: slot_addr = `IF_ADDR_REMOTE_SLAVES;
                2'd2: slot_addr = `IF_ADDR_LOCAL_STATUS;
                default: slot_addr = `IF_ADDR_LOCAL_SLAVES;
            endcase
        end
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    reg [5:0] pin_meta;
    reg [5:0] pin_sync;
    reg [15:0] missing_file_flags;
    reg [7:0] remote_status_raw;
    reg [7:0] remote_slaves;
    reg [7:0] local_status_raw;
    reg [7:0] local_slaves;
    reg outputs_refreshed_flag;
    reg [15:0] redundancy_message_length;
    reg [15:0] passive_backup_status;
    reg [`EV_WIDTH-1:0] event_status;
    reg [`EV_WIDTH-1:0] event_mask;
    reg [1:0] poll_slot;
    reg [1:0] tag_issued;
    reg [1:0] tag_ready;
    reg tag_valid;
    reg tag_ready_valid;

    wire [3:0] file_sync;
    wire standalone_sync;
    wire not_connected_sync;
    wire [15:0] next_missing;
    wire [7:0] remote_status_byte;
    wire [7:0] local_status_byte;
    wire [15:0] remote_redundancy_status;
    wire [15:0] local_redundancy_status;
    wire [`EV_WIDTH-1:0] raised;
    wire [7:0] apb_index;
    wire apb_setup;
    wire apb_done;
    wire status_clear;
    reg [15:0] read_word;
    reg read_hit;

    assign file_sync = pin_sync[3:0];
    assign standalone_sync = pin_sync[4];
    assign not_connected_sync = pin_sync[5];

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************

    // two flops before any logic sees the asynchronous levels
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else begin
            pin_meta <= {i_not_connected, i_standalone, i_file_problem};
            pin_sync <= pin_meta;
        end
    end

    // ****************************************************************
    // file error word and fault lamp
    // ****************************************************************

    assign next_missing = {12'h000, file_sync} & `FILE_FLAGS_MASK;

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            missing_file_flags <= `RST_WORD;
            o_cfg_fault_led <= 1'b0;
        end else begin
            missing_file_flags <= next_missing;
            o_cfg_fault_led <= (next_missing != `RST_WORD);
        end
    end

    // ****************************************************************
    // interface memory poller
    // ****************************************************************

    // round robin over four locations; the ram answers one edge after
    // the address is set and the byte is taken one edge later, so a tag pipeline tracks which byte comes back
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            poll_slot <= 2'd0;
            o_if_addr <= `IF_ADDR_REMOTE_STATUS;
            o_if_rd <= 1'b0;
            tag_issued <= 2'd0;
            tag_valid <= 1'b0;
            tag_ready <= 2'd0;
            tag_ready_valid <= 1'b0;
        end else begin
            poll_slot <= poll_slot + 2'd1;
            o_if_addr <= slot_addr(poll_slot);
            o_if_rd <= 1'b1;
            tag_issued <= poll_slot;
            tag_valid <= 1'b1;
            tag_ready <= tag_issued;
            tag_ready_valid <= tag_valid;
        end
    end

    // capture returned bytes into the raw copies
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            remote_status_raw <= `RST_BYTE;
            remote_slaves <= `RST_BYTE;
            local_status_raw <= `RST_BYTE;
            local_slaves <= `RST_BYTE;
        end else if (tag_ready_valid) begin
            case (tag_ready)
                2'd0: remote_status_raw <= i_if_rdata;
                2'd1: remote_slaves <= i_if_rdata;
                2'd2: local_status_raw <= i_if_rdata;
                default: local_slaves <= i_if_rdata;
            endcase
        end
    end

    // ****************************************************************
    // outputs refreshed flag
    // ****************************************************************

    // a refresh may be reported by the interface byte or the strobe;
    // interface reset and the not-connected state win over a set
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            outputs_refreshed_flag <= 1'b0;
        end else if (i_if_reset || not_connected_sync) begin
            outputs_refreshed_flag <= 1'b0;
        end else if (i_outputs_refreshed || remote_status_raw[`BIT_OUTPUTS_REFRESHED]
                     || local_status_raw[`BIT_OUTPUTS_REFRESHED]) begin
            outputs_refreshed_flag <= 1'b1;
        end
    end

    // ****************************************************************
    // composed status words
    // ****************************************************************

    assign remote_status_byte = clean_status({remote_status_raw[7:5], outputs_refreshed_flag,
                                              remote_status_raw[3:0]});
    // enabled only when paired and connected
    assign local_status_byte = clean_status({~(standalone_sync | not_connected_sync),
                                             local_status_raw[6:5], outputs_refreshed_flag,
                                             local_status_raw[3:0]});
    assign remote_redundancy_status = {remote_slaves, remote_status_byte};
    assign local_redundancy_status = {local_slaves, local_status_byte};

    // ****************************************************************
    // datagram copies
    // ****************************************************************

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            redundancy_message_length <= `RST_WORD;
            passive_backup_status <= `RST_WORD;
        end else if (i_dgram_valid) begin
            redundancy_message_length <= i_dgram_length;
            passive_backup_status <= {i_dgram_status[15:8], clean_status(i_dgram_status[7:0])};
        end
    end

    // ****************************************************************
    // events and interrupt
    // ****************************************************************

    // edges are taken against the composed values of the previous cycle
    reg [7:0] remote_prev;
    reg [7:0] local_prev;
    reg file_prev;
    reg refreshed_prev;

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            remote_prev <= `RST_BYTE;
            local_prev <= `RST_BYTE;
            file_prev <= 1'b0;
            refreshed_prev <= 1'b0;
        end else begin
            remote_prev <= remote_status_byte;
            local_prev <= local_status_byte;
            file_prev <= (missing_file_flags != `RST_WORD);
            refreshed_prev <= outputs_refreshed_flag;
        end
    end

    assign raised[`EV_FILE_FAULT] = (missing_file_flags != `RST_WORD) && !file_prev;
    assign raised[`EV_ROLE_CHANGE] = remote_status_byte[`BIT_PASSIVE_ROLE] != remote_prev[`BIT_PASSIVE_ROLE];
    assign raised[`EV_CRITICAL_ERROR] = local_status_byte[`BIT_CRITICAL_ERROR] && !local_prev[`BIT_CRITICAL_ERROR];
    assign raised[`EV_DATAGRAM] = i_dgram_valid;
    assign raised[`EV_OUTPUTS_REFRESHED] = outputs_refreshed_flag && !refreshed_prev;
    assign raised[`EV_COUNTERPART_LOST] = !remote_status_byte[`BIT_COUNTERPART_PRESENT]
                                          && remote_prev[`BIT_COUNTERPART_PRESENT];

    assign apb_setup = i_psel && !i_penable;
    assign apb_done = i_psel && i_penable && o_pready;
    assign apb_index = word_index(i_paddr);
    assign status_clear = apb_done && i_pwrite && (apb_index == `IDX_EVENT_STATUS);

    // write one clears; a new event in the same cycle wins over the clear
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            event_status <= `RST_EVENTS;
            event_mask <= `RST_EVENTS;
            o_irq <= 1'b0;
        end else begin
            if (status_clear) begin
                event_status <= (event_status & ~i_pwdata[`EV_WIDTH-1:0]) | raised;
            end else begin
                event_status <= event_status | raised;
            end
            if (apb_done && i_pwrite && (apb_index == `IDX_EVENT_MASK)) begin
                event_mask <= i_pwdata[`EV_WIDTH-1:0];
            end
            o_irq <= |(event_status & event_mask);
        end
    end

    // ****************************************************************
    // apb read decode
    // ****************************************************************

    // status words only read here, never written
    always @* begin
        read_word = `RST_WORD;
        read_hit = 1'b1;
        case (apb_index)
            `IDX_MISSING_FILE_FLAGS: read_word = missing_file_flags;
            `IDX_REMOTE_REDUNDANCY_STATUS: read_word = remote_redundancy_status;
            `IDX_LOCAL_REDUNDANCY_STATUS: read_word = local_redundancy_status;
            `IDX_REDUNDANCY_MESSAGE_LENGTH: read_word = redundancy_message_length;
            `IDX_PASSIVE_BACKUP_STATUS: read_word = passive_backup_status;
            `IDX_EVENT_STATUS: read_word = {10'h000, event_status};
            `IDX_EVENT_MASK: read_word = {10'h000, event_mask};
            default: read_hit = 1'b0;
        endcase
    end

    // answer in the first access cycle; data and error latched at setup
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (apb_setup) begin
            o_prdata <= i_pwrite ? 32'h0000_0000 : {16'h0000, read_word};
            o_pready <= 1'b1;
            o_pslverr <= !read_hit;
        end else begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

endmodule // standby_status_bank

/* File: include/standby_status_regs.vh */
// register map, field positions and reset values of the standby status word bank
//
// Notes on behaviour
// - file word bits 0..3 flag four problem files; bits 4..15 read zero
// - fault lamp lit while file word is nonzero, dark while zero
// - remote word: low byte from interface 0xea0, high byte count from 0xea1
// - status bit 0 clear for active master, set for passive master
// - status bit 1 set when all slaves healthy, clear when any offline
// - status bit 2 set while local master sees an active critical error
// - status bit 3 set on database mismatch between masters, clear if consistent
// - status bits 5 and 6 always read zero
// - remote bit 7 set while redundant counterpart module is present
// - local word: low byte from 0xea4, high byte count from 0xea5
// - local bit 7 clear when stand-alone or not connected, else set
// - message length word holds length of last datagram redundancy message
// - passive word: datagram status byte low, passive slave count high
`ifndef STANDBY_STATUS_REGS_VH
`define STANDBY_STATUS_REGS_VH

// ****************************************************************
// register indexes (byte address is four times the index)
// ****************************************************************
`define IDX_MISSING_FILE_FLAGS 8'h3b
`define IDX_REMOTE_REDUNDANCY_STATUS 8'h3c
`define IDX_LOCAL_REDUNDANCY_STATUS 8'h3d
`define IDX_REDUNDANCY_MESSAGE_LENGTH 8'h3e
`define IDX_PASSIVE_BACKUP_STATUS 8'h3f
`define IDX_EVENT_STATUS 8'h40
`define IDX_EVENT_MASK 8'h41

// ****************************************************************
// fieldbus interface memory locations
// ****************************************************************
`define IF_ADDR_REMOTE_STATUS 12'hea0
`define IF_ADDR_REMOTE_SLAVES 12'hea1
`define IF_ADDR_LOCAL_STATUS 12'hea4
`define IF_ADDR_LOCAL_SLAVES 12'hea5

// ****************************************************************
// status byte fields
// ****************************************************************
`define BIT_PASSIVE_ROLE 0
`define BIT_SLAVES_OK 1
`define BIT_CRITICAL_ERROR 2
`define BIT_DATABASE_MISMATCH 3
`define BIT_OUTPUTS_REFRESHED 4
`define BIT_COUNTERPART_PRESENT 7
`define BIT_REDUNDANCY_ENABLED 7
`define FILE_FLAGS_MASK 16'h000f
`define STATUS_UNUSED_MASK 8'h9f

// ****************************************************************
// event bits and reset values
// ****************************************************************
`define EV_FILE_FAULT 0
`define EV_ROLE_CHANGE 1
`define EV_CRITICAL_ERROR 2
`define EV_DATAGRAM 3
`define EV_OUTPUTS_REFRESHED 4
`define EV_COUNTERPART_LOST 5
`define EV_WIDTH 6
`define RST_WORD 16'h0000
`define RST_BYTE 8'h00
`define RST_EVENTS 6'h00

`endif

/* File: bench/iface_mem_model.sv */
// behavioural fieldbus interface memory that answers the status poller
module iface_mem_model (
    input wire logic i_clk_sys,
    input wire logic [11:0] i_addr,
    input wire logic i_rd,
    input wire logic [7:0] i_rem_st,
    input wire logic [7:0] i_rem_cnt,
    input wire logic [7:0] i_loc_st,
    input wire logic [7:0] i_loc_cnt,
    output logic [7:0] o_data
);
    timeunit 1ns;
    timeprecision 1ns;

    initial o_data = 8'h5a;

    // status byte locations
    // one wait state; off the map the bus toggles so stale bytes never look valid
    always @(posedge i_clk_sys) begin
        if (!i_rd) begin
            o_data <= ~o_data;
        end else begin
            case (i_addr)
                12'hea0: o_data <= i_rem_st;
                12'hea1: o_data <= i_rem_cnt;
                12'hea4: o_data <= i_loc_st;
                12'hea5: o_data <= i_loc_cnt;
                default: o_data <= ~o_data;
            endcase
        end
    end
endmodule // iface_mem_model

/* File: bench/standby_status_checker.sv */
// concurrent assertions on the ports of the standby status bank
module standby_status_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [3:0] i_file_problem,
    input wire logic i_standalone,
    input wire logic i_not_connected,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [11:0] o_if_addr,
    input wire logic o_cfg_fault_led
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);

    logic [1:0] lvl_q;
    logic [2:0] quiet;

    // cycles the redundancy level pins have stood still; sync delay must be covered
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lvl_q <= 2'h0;
            quiet <= 3'h0;
        end else begin
            lvl_q <= {i_standalone, i_not_connected};
            if ({i_standalone, i_not_connected} != lvl_q) quiet <= 3'h0;
            else if (quiet != 3'h7) quiet <= quiet + 3'h1;
        end
    end

    sequence apb_setup;
        i_psel && !i_penable;
    endsequence
    sequence file_on;
        (i_file_problem != 4'h0) [*5];
    endsequence
    sequence file_off;
        (i_file_problem == 4'h0) [*5];
    endsequence
    sequence status_read;
        o_pready && !i_pwrite && (i_paddr == 12'h0f0 || i_paddr == 12'h0f4 || i_paddr == 12'h0fc);
    endsequence

    AST_PREADY_AFTER_SETUP: assert property (apb_setup |=> o_pready)
        else $error("no ready after setup");
    AST_PREADY_ONE_CYCLE: assert property (o_pready |=> !o_pready)
        else $error("ready stood longer than one cycle");
    AST_SLVERR_WITH_READY: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    AST_LAMP_LIT: assert property (file_on |-> o_cfg_fault_led)
        else $error("fault lamp dark with file flags set");
    AST_LAMP_DARK: assert property (file_off |-> !o_cfg_fault_led)
        else $error("fault lamp lit with no file flags");
    AST_FILE_UNUSED_ZERO: assert property (o_pready && !i_pwrite && i_paddr == 12'h0ec
        |-> o_prdata[31:4] == 28'h0)
        else $error("file word unused bits not zero");
    AST_STATUS_GAP_ZERO: assert property (status_read |-> o_prdata[6:5] == 2'h0 && o_prdata[31:16] == 16'h0)
        else $error("status gap bits not zero");
    AST_POLL_ORDER: assert property ((o_if_addr == 12'hea1 |=> o_if_addr == 12'hea4)
        and (o_if_addr == 12'hea4 |=> o_if_addr == 12'hea5) and (o_if_addr == 12'hea5 |=> o_if_addr == 12'hea0))
        else $error("interface poll order broken");
    AST_LOCAL_ENABLED: assert property (o_pready && !i_pwrite && i_paddr == 12'h0f4 && quiet >= 3'h5
        |-> o_prdata[7] == !(i_standalone || i_not_connected))
        else $error("local enabled bit wrong");
endmodule // standby_status_checker

bind standby_status_bank standby_status_checker #(.ADDR_W(ADDR_W)) standby_status_checker_i (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_file_problem(i_file_problem), .i_standalone(i_standalone),
    .i_not_connected(i_not_connected), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_if_addr(o_if_addr), .o_cfg_fault_led(o_cfg_fault_led));

/* File: bench/tb.sv */
// self-checking testbench for the standby status word bank
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic i_clk_sys = 1'b0, i_arst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic i_standalone = 1'b0, i_not_connected = 1'b0, i_if_reset = 1'b0, i_outputs_refreshed = 1'b0;
    logic i_dgram_valid = 1'b0, o_pready, o_pslverr, o_if_rd, o_cfg_fault_led, o_irq, err;
    logic [11:0] i_paddr = 12'h000, o_if_addr;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic [31:0] exp_w [5];
    logic [3:0] i_file_problem = 4'h0;
    logic [7:0] i_if_rdata, rem_st = 8'h00, rem_cnt = 8'h00, loc_st = 8'h00, loc_cnt = 8'h00;
    logic [15:0] i_dgram_length = 16'h0, i_dgram_status = 16'h0;
    int fails = 0, checks = 0;

    // 10 MHz system clock
    always #50 i_clk_sys = ~i_clk_sys;

    standby_status_bank #(.ADDR_W(12)) standby_status_bank_i (
        .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_file_problem(i_file_problem),
        .i_standalone(i_standalone), .i_not_connected(i_not_connected), .o_if_addr(o_if_addr),
        .o_if_rd(o_if_rd), .i_if_rdata(i_if_rdata), .i_if_reset(i_if_reset),
        .i_outputs_refreshed(i_outputs_refreshed), .i_dgram_valid(i_dgram_valid),
        .i_dgram_length(i_dgram_length), .i_dgram_status(i_dgram_status),
        .o_cfg_fault_led(o_cfg_fault_led), .o_irq(o_irq));

    iface_mem_model iface_mem_model_i (.i_clk_sys(i_clk_sys), .i_addr(o_if_addr), .i_rd(o_if_rd),
        .i_rem_st(rem_st), .i_rem_cnt(rem_cnt), .i_loc_st(loc_st), .i_loc_cnt(loc_cnt), .o_data(i_if_rdata));

    // ****************************************************************
    // closing, compare and bus tasks
    // ****************************************************************
    task automatic test_done;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // apb transfer; request held until ready is sampled high, bounded wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n == 20) fails++;
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, exp, rd);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask

    // one-cycle strobes on the datagram port
    task automatic dgram(input logic [15:0] len, input logic [15:0] st);
        @(posedge i_clk_sys);
        i_dgram_valid <= 1'b1;
        i_dgram_length <= len;
        i_dgram_status <= st;
        @(posedge i_clk_sys);
        i_dgram_valid <= 1'b0;
        tick(3);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        tick(4);
        i_arst_n <= 1'b1;
        tick(12);
        check("interface read", 32'h1, {31'h0, o_if_rd});
        for (int b = 0; b < 4; b++) begin
            i_file_problem <= 4'h1 << b;
            tick(6);
            rd_chk("file flags", 12'h0ec, 32'h1 << b);
            check("fault lamp", 32'h1, {31'h0, o_cfg_fault_led});
        end
        i_file_problem <= 4'h0;
        tick(6);
        rd_chk("file flags", 12'h0ec, 32'h0);
        check("fault lamp", 32'h0, {31'h0, o_cfg_fault_led});
        // remote status bits 0 to 3 and 7 alone, unused bits driven high to see them masked
        for (int b = 0; b < 8; b++) begin
            if (b < 4 || b == 7) begin
                rem_st <= (8'h1 << b) | 8'h60;
                rem_cnt <= 8'(b + 16);
                tick(12);
                rd_chk("remote word", 12'h0f0, {16'h0, 8'(b + 16), 8'h1 << b});
            end
        end
        rem_st <= 8'h00;
        rem_cnt <= 8'h00;
        loc_st <= 8'hef;
        loc_cnt <= 8'h2a;
        for (int k = 0; k < 4; k++) begin
            {i_standalone, i_not_connected} <= 2'(k);
            tick(12);
            rd_chk("local word", 12'h0f4, {16'h002a, k == 0, 7'h0f});
        end
        {i_standalone, i_not_connected} <= 2'h0;
        tick(6);
        i_outputs_refreshed <= 1'b1;
        tick(1);
        i_outputs_refreshed <= 1'b0;
        tick(20);
        rd_chk("remote refreshed", 12'h0f0, 32'h10);
        rd_chk("local refreshed", 12'h0f4, 32'h2a9f);
        i_if_reset <= 1'b1;
        tick(1);
        i_if_reset <= 1'b0;
        tick(3);
        rd_chk("refreshed after reset", 12'h0f0, 32'h0);
        i_outputs_refreshed <= 1'b1;
        tick(1);
        i_outputs_refreshed <= 1'b0;
        i_not_connected <= 1'b1;
        tick(6);
        rd_chk("refreshed not connected", 12'h0f0, 32'h0);
        i_not_connected <= 1'b0;
        // file, role, critical, refreshed and counterpart events are pending; clear them all
        rd_chk("pending events", 12'h100, 32'h37);
        apb(1'b1, 12'h100, 32'h3f);
        rd_chk("events cleared", 12'h100, 32'h0);
        // datagram event masked, then unmasked, then cleared
        dgram(16'h0123, 16'h1267);
        check("irq masked", 32'h0, {31'h0, o_irq});
        rd_chk("message length", 12'h0f8, 32'h0123);
        rd_chk("passive word", 12'h0fc, 32'h1207);
        apb(1'b1, 12'h104, 32'h08);
        rd_chk("event mask", 12'h104, 32'h08);
        tick(3);
        check("irq raised", 32'h1, {31'h0, o_irq});
        apb(1'b1, 12'h100, 32'h08);
        tick(3);
        check("irq cleared", 32'h0, {31'h0, o_irq});
        dgram(16'hfffe, 16'h3488);
        check("irq again", 32'h1, {31'h0, o_irq});
        rem_st <= 8'h8b;
        rem_cnt <= 8'h07;
        tick(12);
        exp_w = '{32'h0, 32'h078b, 32'h2a8f, 32'hfffe, 32'h3488};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 12'h0ec + 12'(4 * i), 32'hffffffff);
            check("write error", 32'h0, {31'h0, err});
            rd_chk("read only word", 12'h0ec + 12'(4 * i), exp_w[i]);
        end
        apb(1'b0, 12'h000, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        apb(1'b0, 12'h0f2, 32'h0);
        check("misaligned error", 32'h1, {31'h0, err});
        test_done();
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        tick(20000);
        fails++;
        test_done();
    end
endmodule // tb
